// ---- design/gpdl_pkg.sv ----
// Constants and types shared by the GPIO data and lock block
package gpdl_pkg;
   // Port geometry
   localparam int GPDL_PINS = 16;
   localparam int GPDL_ADR_W = 8;
   // Register byte offsets
   localparam logic [7:0] GPDL_OFS_CFG_LO = 8'h00;
   localparam logic [7:0] GPDL_OFS_CFG_HI = 8'h04;
   localparam logic [7:0] GPDL_OFS_INPUT = 8'h08;
   localparam logic [7:0] GPDL_OFS_OUTPUT = 8'h0c;
   localparam logic [7:0] GPDL_OFS_SETCLR = 8'h10;
   localparam logic [7:0] GPDL_OFS_CLEAR = 8'h14;
   localparam logic [7:0] GPDL_OFS_LOCK = 8'h18;
   // Reset values
   localparam logic [31:0] GPDL_RST_CFG = 32'h44444444;
   localparam logic [15:0] GPDL_RST_OUTPUT = 16'h0000;
   localparam logic [15:0] GPDL_RST_MASK = 16'h0000;
   // Field positions
   localparam int GPDL_KEY_POS = 16;
   localparam int GPDL_CLR_POS = 16;
   localparam int GPDL_FIELD_W = 4;
   localparam int GPDL_MODE_POS = 0;
   localparam int GPDL_CTL_POS = 2;
   // Full-word byte enables
   localparam logic [3:0] GPDL_SEL_WORD = 4'hf;
   // Per-pin mode field encoding
   localparam logic [1:0] GPDL_MODE_INPUT = 2'h0;
   localparam logic [1:0] GPDL_MODE_OUT10 = 2'h1;
   localparam logic [1:0] GPDL_MODE_OUT2 = 2'h2;
   localparam logic [1:0] GPDL_MODE_OUT50 = 2'h3;
   // Lock key sequence progress
   typedef enum logic [2:0] {
      GPDL_LK_IDLE,
      GPDL_LK_W1,
      GPDL_LK_W10,
      GPDL_LK_W101,
      GPDL_LK_READ0
   } gpdl_lkst_t;
endpackage

// ---- design/gpdl_pin_sync.sv ----
// Two-flop synchroniser for the port pin levels
`timescale 1ns/1ps
module gpdl_pin_sync #(
   parameter int WIDTH = 16
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Asynchronous levels in, synchronised levels out
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] meta; // First stage, read only by the second

   ////////////////////////////////////////////////////////////////
   // Both stages; the first may go metastable, the second settles it
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '0;
         syncOut <= '0;
      end else begin
         meta <= asyncIn;
         syncOut <= meta;
      end
   end
endmodule

// ---- design/gpdl_lock_seq.sv ----
// Lock key sequence tracker with the per-pin lock mask
`timescale 1ns/1ps
module gpdl_lock_seq
   import gpdl_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Completed accesses to the lock register
   input wire logic lockWrite,
   input wire logic lockRead,
   input wire logic [31:0] wrData,
   // Lock state
   output logic lockKey,
   output logic [GPDL_PINS-1:0] lockMask
);
   gpdl_lkst_t state; // Sequence progress
   gpdl_lkst_t next_state;
   logic keyIn; // Key bit of the write
   logic sameMask; // Mask held since sequence start
   logic finish; // Read of zero after the writes

   assign keyIn = wrData[GPDL_KEY_POS];
   assign sameMask = (wrData[GPDL_PINS-1:0] == lockMask);
   assign finish = lockRead && (state == GPDL_LK_W101);

   ////////////////////////////////////////////////////////////////
   // Sequence decoder: write 1, write 0, write 1, read 0, read 1
   always_comb begin
      next_state = state;
      case (state)
         GPDL_LK_IDLE: begin
            if (lockWrite && keyIn) begin
               next_state = GPDL_LK_W1;
            end
         end
         GPDL_LK_W1: begin
            if (lockWrite) begin
               // A repeated 1 restarts the sequence with the new mask
               next_state = (!keyIn && sameMask) ? GPDL_LK_W10 :
                            (keyIn ? GPDL_LK_W1 : GPDL_LK_IDLE);
            end else if (lockRead) begin
               next_state = GPDL_LK_IDLE;
            end
         end
         GPDL_LK_W10: begin
            if (lockWrite) begin
               next_state = (keyIn && sameMask) ? GPDL_LK_W101 : GPDL_LK_IDLE;
            end else if (lockRead) begin
               next_state = GPDL_LK_IDLE;
            end
         end
         GPDL_LK_W101: begin
            if (lockWrite) begin
               next_state = keyIn ? GPDL_LK_W1 : GPDL_LK_IDLE;
            end else if (lockRead) begin
               next_state = GPDL_LK_READ0;
            end
         end
         GPDL_LK_READ0: begin
            // Key is already set; the closing read returns one
            next_state = GPDL_LK_READ0;
         end
         default: begin
            next_state = GPDL_LK_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////
   // Key and mask; once the key is set nothing changes until reset
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= GPDL_LK_IDLE;
         lockKey <= 1'b0;
         lockMask <= GPDL_RST_MASK;
      end else if (!lockKey) begin
         state <= next_state;
         if (finish) begin
            lockKey <= 1'b1;
         end
         if (lockWrite) begin
            lockMask <= wrData[GPDL_PINS-1:0];
         end
      end
   end
endmodule

// ---- design/gpdl_port.sv ----
// Sixteen-pin GPIO port: data registers, mode fields and config lock
`timescale 1ns/1ps
module gpdl_port
   import gpdl_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [GPDL_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Port pins, split into level, drive and enable
   input wire logic [GPDL_PINS-1:0] pinIn,
   output logic [GPDL_PINS-1:0] pinOut,
   output logic [GPDL_PINS-1:0] pinOe_n,
   // Lock state for neighbouring configuration logic
   output logic lockKeyOut
);

   ////////////////////////////////////////////////////////////////
   // Declarations
   logic [GPDL_PINS-1:0] pinLevel; // Synchronised pin levels
   logic [GPDL_PINS-1:0] outputLatch; // Output data latch
   logic [GPDL_PINS-1:0] next_outputLatch;
   logic [2*32-1:0] modeCfg; // Mode and config fields, four bits per pin
   logic [2*32-1:0] next_modeCfg;
   logic lockKey; // Key bit from the sequence tracker
   logic [GPDL_PINS-1:0] lockMask; // Per-pin lock mask
   logic [GPDL_PINS-1:0] pinLocked; // Mask gated by key
   logic request; // Bus request pending
   logic accept; // Access completes this cycle
   logic wordWrite; // Full-word write completing
   logic anyRead; // Read completing
   logic [31:0] readMux; // Read data for the current address
   logic hitCfgLo, hitCfgHi, hitInput, hitOutput;
   logic hitSetClr, hitClear, hitLock;
   logic [GPDL_PINS-1:0] setReq; // Set bits of this write
   logic [GPDL_PINS-1:0] clrReq; // Clear bits of this write
   logic [GPDL_PINS-1:0] next_pinOut;
   logic [GPDL_PINS-1:0] next_pinOe_n;

   ////////////////////////////////////////////////////////////////
   // Address match, used for every register
   function automatic logic adrIs(input logic [GPDL_ADR_W-1:0] adr,
                                  input logic [7:0] ofs);
      adrIs = (adr[GPDL_ADR_W-1:2] == ofs[GPDL_ADR_W-1:2]);
   endfunction

   // Mode field of one pin from the packed configuration
   function automatic logic [1:0] modeOf(input logic [2*32-1:0] cfg,
                                         input int pin);
      modeOf = cfg[pin*GPDL_FIELD_W+GPDL_MODE_POS +: 2];
   endfunction

   // Config field of one pin from the packed configuration
   function automatic logic [1:0] ctlOf(input logic [2*32-1:0] cfg,
                                        input int pin);
      ctlOf = cfg[pin*GPDL_FIELD_W+GPDL_CTL_POS +: 2];
   endfunction

   ////////////////////////////////////////////////////////////////
   // Pin input synchroniser; pins are asynchronous to ref_clk
   gpdl_pin_sync #(
      .WIDTH(GPDL_PINS)
   ) u_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .asyncIn(pinIn),
      .syncOut(pinLevel)
   );

   ////////////////////////////////////////////////////////////////
   // Bus handshake: ack follows the request by one cycle, one cycle long
   assign request = wb_cyc_i && wb_stb_i;
   assign accept = request && wb_ack_o;
   // Partial writes are dropped: the registers are word-only
   assign wordWrite = accept && wb_we_i && (wb_sel_i == GPDL_SEL_WORD);
   assign anyRead = accept && !wb_we_i;

   // Register decode
   assign hitCfgLo = adrIs(wb_adr_i, GPDL_OFS_CFG_LO);
   assign hitCfgHi = adrIs(wb_adr_i, GPDL_OFS_CFG_HI);
   assign hitInput = adrIs(wb_adr_i, GPDL_OFS_INPUT);
   assign hitOutput = adrIs(wb_adr_i, GPDL_OFS_OUTPUT);
   assign hitSetClr = adrIs(wb_adr_i, GPDL_OFS_SETCLR);
   assign hitClear = adrIs(wb_adr_i, GPDL_OFS_CLEAR);
   assign hitLock = adrIs(wb_adr_i, GPDL_OFS_LOCK);

   ////////////////////////////////////////////////////////////////
   // Read data selection; unmapped and write-only addresses read zero
   always_comb begin
      readMux = 32'h00000000;
      if (hitCfgLo) begin
         readMux = modeCfg[31:0];
      end else if (hitCfgHi) begin
         readMux = modeCfg[63:32];
      end else if (hitInput) begin
         readMux = {16'h0000, pinLevel};
      end else if (hitOutput) begin
         readMux = {16'h0000, outputLatch};
      end else if (hitLock) begin
         // Key always readable
         readMux = {15'h0000, lockKey, lockMask};
      end
   end

   ////////////////////////////////////////////////////////////////
   // Bus answer registers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= request && !wb_ack_o;
         wb_dat_o <= (request && !wb_ack_o) ? readMux : 32'h00000000;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Lock key sequence and mask
   gpdl_lock_seq u_lock (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .lockWrite(wordWrite && hitLock),
      .lockRead(anyRead && hitLock),
      .wrData(wb_dat_i),
      .lockKey(lockKey),
      .lockMask(lockMask)
   );

   assign pinLocked = lockKey ? lockMask : '0;

   ////////////////////////////////////////////////////////////////
   // Output latch: direct write, atomic set/clear, clear-only
   assign setReq = (wordWrite && hitSetClr) ? wb_dat_i[GPDL_PINS-1:0] : '0;
   assign clrReq = (wordWrite && hitSetClr) ?
                   wb_dat_i[GPDL_CLR_POS +: GPDL_PINS] :
                   ((wordWrite && hitClear) ? wb_dat_i[GPDL_PINS-1:0] : '0);

   always_comb begin
      next_outputLatch = outputLatch;
      if (wordWrite && hitOutput) begin
         next_outputLatch = wb_dat_i[GPDL_PINS-1:0];
      end else begin
         // Zeros leave bits alone; set applied last so it wins
         next_outputLatch = (outputLatch & ~clrReq) | setReq;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Mode and config fields, each pin guarded by its lock bit
   generate
      for (genvar p = 0; p < GPDL_PINS; p++) begin : g_field
         localparam int BASE = p * GPDL_FIELD_W;
         logic hitField; // Write reaches this pin's field
         assign hitField = wordWrite && ((p < 8) ? hitCfgLo : hitCfgHi);
         // Locked fields keep their value; the write is silently lost
         assign next_modeCfg[BASE +: GPDL_FIELD_W] =
            (hitField && !pinLocked[p]) ?
            wb_dat_i[(BASE % 32) +: GPDL_FIELD_W] :
            modeCfg[BASE +: GPDL_FIELD_W];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////
   // Pin drive: input mode floats; open-drain drives only low
   generate
      for (genvar q = 0; q < GPDL_PINS; q++) begin : g_drive
         logic isOutput; // Any nonzero mode selects output
         logic openDrain; // Config bit zero in output mode
         logic [1:0] cfgBits; // Config field of this pin
         assign isOutput = (modeOf(modeCfg, q) != GPDL_MODE_INPUT);
         // Named wire: a select straight on a call result is refused by strict tools
         assign cfgBits = ctlOf(modeCfg, q);
         assign openDrain = cfgBits[0];
         assign next_pinOut[q] = outputLatch[q];
         assign next_pinOe_n[q] = !(isOutput && !(openDrain && outputLatch[q]));
      end
   endgenerate

   ////////////////////////////////////////////////////////////////
   // Data and configuration state
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         outputLatch <= GPDL_RST_OUTPUT;
         modeCfg <= {GPDL_RST_CFG, GPDL_RST_CFG};
      end else begin
         outputLatch <= next_outputLatch;
         modeCfg <= next_modeCfg;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Registered pin and lock outputs
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pinOut <= '0;
         pinOe_n <= '1;
         lockKeyOut <= 1'b0;
      end else begin
         pinOut <= next_pinOut;
         pinOe_n <= next_pinOe_n;
         lockKeyOut <= lockKey;
      end
   end
endmodule

// ---- testbench/gpdl_port_asserts.sv ----
// Checker for the GPIO data and lock block ports
`timescale 1ns/1ps
module gpdl_port_asserts
   import gpdl_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [GPDL_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Pins and lock
   input wire logic [GPDL_PINS-1:0] pinIn,
   input wire logic [GPDL_PINS-1:0] pinOut,
   input wire logic [GPDL_PINS-1:0] pinOe_n,
   input wire logic lockKeyOut
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // Decoded word address and completed accesses
   wire logic [5:0] wa = wb_adr_i[7:2];
   wire logic rdAck = wb_ack_o && !wb_we_i;
   wire logic wrAck = wb_ack_o && wb_we_i && wb_sel_i == GPDL_SEL_WORD;
   wire logic lockRd = rdAck && wa == GPDL_OFS_LOCK[7:2];
   wire logic [15:0] wLo = wb_dat_i[15:0];
   wire logic [15:0] wHi = wb_dat_i[31:16];
   // Pin stability count; reads only judged once sync has settled
   logic [15:0] pinPrev;
   logic [2:0] stCnt;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pinPrev <= 16'h0000;
         stCnt <= 3'h0;
      end else begin
         pinPrev <= pinIn;
         stCnt <= (pinIn != pinPrev) ? 3'h0 : ((stCnt == 3'h7) ? stCnt : stCnt + 3'h1);
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   a_ack_latency: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_input_level: assert property (
      (rdAck && wa == GPDL_OFS_INPUT[7:2] && stCnt >= 3'h4) |-> wb_dat_o[15:0] == pinIn)
      else $error("input read differs from pins");
   a_input_upper: assert property (
      (rdAck && wa == GPDL_OFS_INPUT[7:2]) |-> wb_dat_o[31:16] == 16'h0000)
      else $error("input upper half not zero");
   a_output_upper: assert property (
      (rdAck && wa == GPDL_OFS_OUTPUT[7:2]) |-> wb_dat_o[31:16] == 16'h0000)
      else $error("output upper half not zero");
   a_wo_zero: assert property (
      (rdAck && (wa == GPDL_OFS_SETCLR[7:2] || wa == GPDL_OFS_CLEAR[7:2])) |-> wb_dat_o == 0)
      else $error("write-only register read not zero");
   a_latch_drive: assert property (
      (wrAck && wa == GPDL_OFS_OUTPUT[7:2]) |-> ##2 pinOut == $past(wLo, 2))
      else $error("pin drive differs from written latch");
   a_set_bits: assert property (
      (wrAck && wa == GPDL_OFS_SETCLR[7:2]) |-> ##2 (pinOut & $past(wLo, 2)) == $past(wLo, 2))
      else $error("set request not applied");
   a_clr_bits: assert property (
      (wrAck && wa == GPDL_OFS_SETCLR[7:2]) |-> ##2 (pinOut & $past(wHi, 2) & ~$past(wLo, 2)) == 0)
      else $error("clear request not applied");
   a_clr_only: assert property (
      (wrAck && wa == GPDL_OFS_CLEAR[7:2]) |-> ##2 (pinOut & $past(wLo, 2)) == 16'h0000)
      else $error("clear-only request not applied");
   a_keep_bits: assert property (
      (wrAck && wa == GPDL_OFS_CLEAR[7:2])
      |-> ##2 (pinOut & ~$past(wLo, 2)) == ($past(pinOut) & ~$past(wLo, 2)))
      else $error("untouched latch bit changed");
   a_key_held: assert property (lockKeyOut |=> lockKeyOut)
      else $error("lock key dropped without reset");
   a_key_by_read: assert property ($rose(lockKeyOut) |-> $past(lockRd, 2))
      else $error("lock key rose without a lock read");
endmodule

bind gpdl_port gpdl_port_asserts chk_i (.ref_clk(ref_clk), .rst_n(rst_n),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .pinIn(pinIn), .pinOut(pinOut), .pinOe_n(pinOe_n), .lockKeyOut(lockKeyOut));

// ---- testbench/gpdl_pin_model.sv ----
// Pin-side model: resolves the port pins from all drivers
`timescale 1ns/1ps
module gpdl_pin_model (
   // Design side
   input wire logic [15:0] pinOut,
   input wire logic [15:0] pinOe_n,
   // Outside driver level on released pins
   input wire logic [15:0] extLevel,
   // Resolved levels back to the design
   output logic [15:0] pinIn
);
   // Enabled pins show their own drive, released ones the outside level
   assign pinIn = (pinOut & ~pinOe_n) | (extLevel & pinOe_n);
endmodule

// ---- testbench/tb_gpdl_port.sv ----
// Self-checking bench for the GPIO data and lock block
`timescale 1ns/1ps
module tb_gpdl_port
   import gpdl_pkg::*;
;
   // Clock, reset, bus and pins
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, lockKeyOut;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 32'h0, datO;
   logic [15:0] pinIn, pinOut, pinOe_n;
   logic [15:0] extLevel = 16'h0000;
   int errTotal = 0;
   int testsRun = 0;
   always #5 ref_clk = ~ref_clk;
   gpdl_port uut (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(datO),
      .wb_ack_o(ack), .pinIn(pinIn), .pinOut(pinOut), .pinOe_n(pinOe_n),
      .lockKeyOut(lockKeyOut));
   gpdl_pin_model pins (.pinOut(pinOut), .pinOe_n(pinOe_n), .extLevel(extLevel),
      .pinIn(pinIn));
   ////////////////////////////////////////////////////////////////////////////////
   // One classic cycle; waits for ack, bounded
   task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] q);
      int n;
      n = 0;
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= s;
      @(posedge ref_clk);
      while (ack !== 1'b1 && n < 20) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 20) begin
         // A missing answer ends the run through the one closing path
         $display("mismatch ack expected 1 seen %b", ack);
         errTotal++;
         report_and_stop();
      end
      q = datO;
      cyc <= 1'b0; stb <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
      logic [31:0] q;
      wbx(1'b1, a, d, s, q);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      wbx(1'b0, a, 32'h0, 4'hf, q);
   endtask
   // Compare and count
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      testsRun++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", nm, e, g);
         errTotal++;
      end
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", testsRun, errTotal);
      if (errTotal == 0 && testsRun > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_input();
      logic [31:0] q;
      extLevel <= 16'ha5c3;
      repeat (4) @(posedge ref_clk);
      rd(GPDL_OFS_INPUT, q); chk("input", 32'h0000a5c3, q);
      wr(GPDL_OFS_INPUT, 32'hffff0000);
      rd(GPDL_OFS_INPUT, q); chk("input written", 32'h0000a5c3, q);
      rd(8'h1c, q); chk("unmapped", 32'h0, q);
      $display("test input done");
   endtask
   task automatic t_output();
      logic [31:0] q;
      rd(GPDL_OFS_OUTPUT, q); chk("latch reset", 32'h0, q);
      wr(GPDL_OFS_OUTPUT, 32'hffff1234);
      rd(GPDL_OFS_OUTPUT, q); chk("latch", 32'h00001234, q);
      wr(GPDL_OFS_OUTPUT, 32'h0000ffff, 4'h3);
      rd(GPDL_OFS_OUTPUT, q); chk("part write", 32'h00001234, q);
      // Every mode code on pins 0 to 7
      for (int m = 0; m < 4; m++) begin
         wr(GPDL_OFS_CFG_LO, {8{2'b00, m[1:0]}});
         repeat (2) @(posedge ref_clk);
         chk("enable", (m == 0) ? 32'hff : 32'h0, {24'h0, pinOe_n[7:0]});
      end
      repeat (4) @(posedge ref_clk);
      rd(GPDL_OFS_INPUT, q); chk("driven pins", 32'h0000a534, q);
      $display("test output done");
   endtask
   task automatic t_setclr();
      logic [31:0] q;
      wr(GPDL_OFS_OUTPUT, 32'h000000f0);
      wr(GPDL_OFS_SETCLR, 32'h00310003);
      rd(GPDL_OFS_OUTPUT, q); chk("set clear", 32'h000000c3, q);
      wr(GPDL_OFS_CLEAR, 32'hffff0080);
      rd(GPDL_OFS_OUTPUT, q); chk("clear only", 32'h00000043, q);
      rd(GPDL_OFS_SETCLR, q); chk("set clear read", 32'h0, q);
      $display("test set clear done");
   endtask
   task automatic t_lock();
      logic [31:0] q;
      rd(GPDL_OFS_LOCK, q); chk("lock reset", 32'h0, q);
      wr(GPDL_OFS_LOCK, 32'h000100ff);
      rd(GPDL_OFS_LOCK, q); chk("plain key", 32'h000000ff, q);
      // Mask changed mid-sequence
      wr(GPDL_OFS_LOCK, 32'h000100ff); wr(GPDL_OFS_LOCK, 32'h000000f0);
      wr(GPDL_OFS_LOCK, 32'h000100ff); rd(GPDL_OFS_LOCK, q);
      rd(GPDL_OFS_LOCK, q); chk("aborted key", 32'h000000ff, q);
      wr(GPDL_OFS_LOCK, 32'h000100ff); wr(GPDL_OFS_LOCK, 32'h000000ff);
      wr(GPDL_OFS_LOCK, 32'h000100ff);
      rd(GPDL_OFS_LOCK, q); chk("key read zero", 32'h000000ff, q);
      rd(GPDL_OFS_LOCK, q); chk("key read one", 32'h000100ff, q);
      chk("key out", 32'h1, {31'h0, lockKeyOut});
      wr(GPDL_OFS_LOCK, 32'h0);
      rd(GPDL_OFS_LOCK, q); chk("frozen", 32'h000100ff, q);
      wr(GPDL_OFS_CFG_LO, 32'h0);
      rd(GPDL_OFS_CFG_LO, q); chk("locked cfg", 32'h33333333, q);
      wr(GPDL_OFS_CFG_HI, 32'h11111111);
      rd(GPDL_OFS_CFG_HI, q); chk("free cfg", 32'h11111111, q);
      $display("test lock done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      t_input();
      t_output();
      t_setclr();
      t_lock();
      report_and_stop();
   end
   // Watchdog, far beyond the roughly 140 cycles needed
   initial begin
      repeat (5000) @(posedge ref_clk);
      errTotal++;
      report_and_stop();
   end
endmodule
